// ==== bench/proc_model.sv ====
// far side: processor status lines and bus-controller ready
`timescale 1ns/1ps
`default_nettype none
module proc_model (
   input  wire logic       clk,
   input  wire logic       start,
   input  wire logic [2:0] code,
   input  wire logic [3:0] waits,
   input  wire logic       strap_lo,
   output logic            m,
   output logic            s1,
   output logic            s0,
   output logic            ready_n
);
   logic [5:0] n_q = 6'h00;
   logic       on;
   always_ff @(posedge clk) begin
      if (start)
         n_q <= 6'h01;
      else if (n_q == 6'(2 * waits + 4))
         n_q <= 6'h00;
      else if (n_q != 6'h00)
         n_q <= n_q + 6'h01;
   end
   // code held two clocks: one sampling edge sees it
   assign on      = (n_q == 6'h01) || (n_q == 6'h02);
   assign m       = on ? code[2] : 1'b1;
   assign s1      = on ? code[1] : 1'b1;
   assign s0      = strap_lo ? 1'b0 : (on ? code[0] : 1'b1);
   assign ready_n = !(n_q > 6'(2 * waits + 2));
endmodule : proc_model
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the processor-side arbiter
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       clk = 0, nrst = 0, prst = 0, sel = 0, lock_n = 1, rm = 1, crq = 1, pri = 0, go = 0, lo = 0;
   logic [2:0] code = 3'h7;
   logic       m, s1, s0, rdy_n, req_n, aen_n, boe, hm, ar;
   logic       busy, cro;
   logic [2:0] kind;
   logic [1:0] st;
   int         miscompares = 0, check_count = 0;
   arb_proc_side dut (.clk(clk), .nrst(nrst), .proc_reset(prst), .mem_io_select(m), .status_bit_one(s1),
      .status_zero_or_hold_strap(s0), .system_bus_select(sel), .ready_n(rdy_n), .lock_n(lock_n),
      .release_mode_strap(rm), .common_request_line_in(crq), .priority_input(pri),
      .common_request_line_out(), .common_request_line_oe(cro), .shared_bus_request_out(req_n), .busy_out(busy),
      .busy_oe(boe), .address_enable_out(aen_n), .hold_mode(hm), .always_release(ar), .cycle_kind(kind),
      .bus_state(st));
   proc_model far (.clk(clk), .start(go), .code(code), .waits(4'h2), .strap_lo(lo), .m(m), .s1(s1), .s0(s0),
      .ready_n(rdy_n));
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic test_done;
      if (miscompares == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   task automatic t_straps(input logic l, input logic md);
      @(posedge clk);
      prst <= 1'b1;
      lo <= l;
      rm <= md;
      tick(4);
      chk({req_n, aen_n, boe}, 3'h6);
      @(posedge clk);
      prst <= 1'b0;
      @(posedge clk);
      lo <= 1'b0;
      tick(4);
      chk(3'(hm), 3'(!l));
      chk(3'(ar), 3'(!md));
   endtask : t_straps
   task automatic t_cycle(input logic [2:0] c, input logic s, input arb_pkg::cyc_kind_e k);
      int i;
      @(posedge clk);
      code <= c;
      sel <= s;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (i = 0; i < 8 && st !== 2'(arb_pkg::ST_COMMAND); i++) tick(1);
      tick(2);
      chk(kind, 3'(k));
      chk({1'b0, req_n, aen_n}, s ? 3'h0 : 3'h3);
      chk({busy, cro, boe}, {2'b00, s});
      for (i = 0; i < 20 && st !== 2'(arb_pkg::ST_IDLE); i++) tick(1);
      chk(3'(st), 3'(arb_pkg::ST_IDLE));
      tick(6);
   endtask : t_cycle
   initial begin
      logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
      arb_pkg::cyc_kind_e kinds [6] = '{arb_pkg::CYC_INTA, arb_pkg::CYC_IORD, arb_pkg::CYC_IOWR,
         arb_pkg::CYC_HALT, arb_pkg::CYC_MEMRD, arb_pkg::CYC_MEMWR};
      repeat (8) @(posedge clk);
      chk({req_n, aen_n, boe}, 3'h6);
      nrst <= 1'b1;
      t_straps(1'b0, 1'b1);
      t_straps(1'b1, 1'b0);
      for (int j = 0; j < 6; j++) begin
         t_cycle(codes[j], 1'b1, kinds[j]);
         chk(3'(req_n), 3'h1);
      end
      t_cycle(3'h5, 1'b0, arb_pkg::CYC_MEMRD);
      @(posedge clk);
      code <= 3'h7;
      sel <= 1'b1;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      tick(8);
      chk({st, req_n}, {2'(arb_pkg::ST_IDLE), 1'b1});
      t_straps(1'b1, 1'b1);
      @(posedge clk);
      lock_n <= 1'b0;
      crq <= 1'b0;
      pri <= 1'b1;
      t_cycle(3'h6, 1'b1, arb_pkg::CYC_MEMWR);
      chk(3'(req_n), 3'h0);
      @(posedge clk);
      lock_n <= 1'b1;
      tick(6);
      chk(3'(req_n), 3'h1);
      @(posedge clk);
      crq <= 1'b1;
      pri <= 1'b0;
      t_cycle(3'h5, 1'b1, arb_pkg::CYC_MEMRD);
      chk(3'(req_n), 3'h0);
      t_straps(1'b1, 1'b1);
      test_done();
   end
   initial begin
      #200us;
      miscompares++;
      test_done();
   end
endmodule : testbench
`default_nettype wire

// ==== logic/arb_proc_side.sv ====
// processor-side arbiter: bus states, cycle decode, request/retain/release
// Overview of operation
// - state changes only on falling clock edge
// - latch hold/status strap at reset fall
// - either status bit low starts cycle
// - decode select and status to cycle kind
// - system select high after status requests bus
// - resample select each edge until ready or high
// - ready low ends the current cycle
// - lock low forbids giving bus away
// - lock sampled at end of each state
// - one status then command states until ready
// - always-release strap releases at the first idle state after a cycle
// - default mode releases on common request/priority
// - reset clears request, busy, enable; abandons cycle
`timescale 1ns/1ps
`default_nettype none
`include "arb_cfg.svh"
module arb_proc_side (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        proc_reset,
   input  wire logic        mem_io_select,
   input  wire logic        status_bit_one,
   input  wire logic        status_zero_or_hold_strap,
   input  wire logic        system_bus_select,
   input  wire logic        ready_n,
   input  wire logic        lock_n,
   input  wire logic        release_mode_strap,
   input  wire logic        common_request_line_in,
   input  wire logic        priority_input,
   output logic             common_request_line_out,
   output logic             common_request_line_oe,
   output logic             shared_bus_request_out,
   output logic             busy_out,
   output logic             busy_oe,
   output logic             address_enable_out,
   output logic             hold_mode,
   output logic             always_release,
   output logic [2:0]       cycle_kind,
   output logic [1:0]       bus_state
);
   arb_dec_if d ();
   arb_status_decode u_dec (.d(d));

   // falling system clock edge seen as a one-cycle enable on clk
   logic sysclk_q;
   logic fall_en;
   always_ff @(posedge clk) begin
      if (!nrst) sysclk_q <= `ARB_DIV_RESET;
      else       sysclk_q <= ~sysclk_q;
   end
   assign fall_en = sysclk_q;

   // status zero taken inverted when hold mode strapped
   logic s0_eff;
   assign s0_eff = hold_mode ? ~status_zero_or_hold_strap : status_zero_or_hold_strap;
   assign d.code = {mem_io_select, status_bit_one, s0_eff};

   // straps caught on the falling edge of processor reset
   logic prst_q;
   always_ff @(posedge clk) begin
      if (!nrst) prst_q <= 1'b0;
      else       prst_q <= proc_reset;
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         hold_mode      <= 1'b0;
         always_release <= 1'b0;
      end else if (prst_q && !proc_reset) begin
         hold_mode      <= status_zero_or_hold_strap == `ARB_STRAP_HOLD;
         always_release <= release_mode_strap == `ARB_STRAP_ALWAYS;
      end
   end

   arb_pkg::bus_state_e state_q;
   logic                need_q;
   logic                own_q;
   logic                locked_q;
   logic                cyc_end;
   logic                give_up;

   assign cyc_end = fall_en && state_q == arb_pkg::ST_COMMAND && !ready_n;
   assign give_up = !locked_q &&
                    (always_release || !common_request_line_in || priority_input);

   // strap edge counts as reset: the strap pin may still read as a status
   always_ff @(posedge clk) begin
      if (!nrst || proc_reset || prst_q) begin
         state_q <= arb_pkg::ST_IDLE;
      end else if (fall_en) begin
         case (state_q)
            arb_pkg::ST_IDLE:    if (d.start) state_q <= arb_pkg::ST_STATUS;
            arb_pkg::ST_STATUS:  state_q <= arb_pkg::ST_COMMAND;
            arb_pkg::ST_COMMAND: if (!ready_n) state_q <= d.start ? arb_pkg::ST_STATUS : arb_pkg::ST_IDLE;
            default:             state_q <= arb_pkg::ST_IDLE;
         endcase
      end
   end

   // lock sampled at each state boundary
   always_ff @(posedge clk) begin
      if (!nrst || proc_reset) locked_q <= 1'b0;
      else if (fall_en)        locked_q <= !lock_n;
   end

   // kind of the cycle latched on entry to status
   always_ff @(posedge clk) begin
      if (!nrst || proc_reset || prst_q)                   cycle_kind <= arb_pkg::CYC_IDLE;
      else if (fall_en && d.start && (state_q == arb_pkg::ST_IDLE || cyc_end)) cycle_kind <= d.kind;
   end

   // select sampled from end of status until ready or high
   always_ff @(posedge clk) begin
      if (!nrst || proc_reset) begin
         need_q <= 1'b0;
      end else if (fall_en) begin
         if (state_q == arb_pkg::ST_STATUS)
            need_q <= system_bus_select && arb_pkg::cyc_kind_e'(cycle_kind) != arb_pkg::CYC_IDLE;
         else if (state_q == arb_pkg::ST_COMMAND && ready_n && !need_q)
            need_q <= system_bus_select;
         else if (cyc_end)
            need_q <= 1'b0;
      end
   end

   // ownership: taken when needed, dropped while idle per mode
   always_ff @(posedge clk) begin
      if (!nrst || proc_reset) begin
         own_q <= 1'b0;
      end else if (fall_en) begin
         if (need_q || (state_q == arb_pkg::ST_STATUS && system_bus_select
                        && arb_pkg::cyc_kind_e'(cycle_kind) != arb_pkg::CYC_IDLE))
            own_q <= 1'b1;
         else if (state_q == arb_pkg::ST_IDLE && give_up)
            own_q <= 1'b0;
      end
   end

   assign bus_state               = state_q;
   assign shared_bus_request_out  = ~own_q;       // active low
   assign address_enable_out      = ~own_q;       // active low
   assign busy_out                = 1'b0;
   assign busy_oe                 = own_q;
   assign common_request_line_out = 1'b0;
   assign common_request_line_oe  = need_q && !own_q;

   a_reset_clears: assert property (@(posedge clk) disable iff (!nrst)
      proc_reset |=> shared_bus_request_out && address_enable_out && !busy_oe)
      else $error("reset did not clear bus outputs");
   a_lock_holds: assert property (@(posedge clk) disable iff (!nrst || proc_reset)
      own_q && locked_q |=> own_q)
      else $error("bus released while locked");

   // enabled edges in each bus state, plus the strap edge
   sequence s_status_edge;
      fall_en && state_q == arb_pkg::ST_STATUS;
   endsequence
   sequence s_idle_edge;
      fall_en && state_q == arb_pkg::ST_IDLE;
   endsequence
   sequence s_cmd_wait;
      fall_en && state_q == arb_pkg::ST_COMMAND && ready_n;
   endsequence
   sequence s_strap_edge;
      prst_q && !proc_reset;
   endsequence

   a_status_cmd: assert property (@(posedge clk) disable iff (!nrst || proc_reset)
      s_status_edge |=> state_q == arb_pkg::ST_COMMAND)
      else $error("status not followed by command");
   a_ready_ends: assert property (@(posedge clk) disable iff (!nrst || proc_reset)
      cyc_end |=> state_q != arb_pkg::ST_COMMAND)
      else $error("ready low did not end cycle");
   a_start_cycle: assert property (@(posedge clk) disable iff (!nrst || proc_reset || prst_q)
      fall_en && state_q == arb_pkg::ST_IDLE && d.start |=> state_q == arb_pkg::ST_STATUS)
      else $error("status low did not start cycle");
   a_no_rise_chg: assert property (@(posedge clk) disable iff (!nrst || proc_reset)
      !fall_en |=> $stable(state_q))
      else $error("state changed off the falling edge");
   a_select_req: assert property (@(posedge clk) disable iff (!nrst || proc_reset)
      fall_en && state_q == arb_pkg::ST_STATUS && system_bus_select
      && arb_pkg::cyc_kind_e'(cycle_kind) != arb_pkg::CYC_IDLE |=> !shared_bus_request_out)
      else $error("select high did not request bus");
   a_idle_noreq: assert property (@(posedge clk) disable iff (!nrst || proc_reset)
      !own_q && state_q == arb_pkg::ST_IDLE && !need_q |=> shared_bus_request_out)
      else $error("bus requested without need");

   // strap capture
   a_strap_hold: assert property (@(posedge clk) disable iff (!nrst)
      s_strap_edge |=> hold_mode == $past(status_zero_or_hold_strap))
      else $error("hold strap not latched");
   a_strap_release: assert property (@(posedge clk) disable iff (!nrst)
      s_strap_edge |=> always_release == !$past(release_mode_strap))
      else $error("release strap not latched");

   // lock, wait states, late select
   a_lock_sample: assert property (@(posedge clk) disable iff (!nrst || proc_reset)
      fall_en |=> locked_q == !$past(lock_n))
      else $error("lock not sampled at state end");
   a_cmd_repeat: assert property (@(posedge clk) disable iff (!nrst || proc_reset || prst_q)
      s_cmd_wait |=> state_q == arb_pkg::ST_COMMAND)
      else $error("command ended while ready high");
   a_cmd_hold: assert property (@(posedge clk) disable iff (!nrst || proc_reset || prst_q)
      !fall_en && state_q == arb_pkg::ST_COMMAND |=> state_q == arb_pkg::ST_COMMAND)
      else $error("command left off the falling edge");
   a_select_late: assert property (@(posedge clk) disable iff (!nrst || proc_reset || prst_q)
      s_cmd_wait ##0 (!need_q && system_bus_select) |=> need_q)
      else $error("late select not taken");

   // release and cycle kind
   a_release_mode: assert property (@(posedge clk) disable iff (!nrst || proc_reset)
      s_idle_edge ##0 (own_q && give_up && !need_q) |=> !own_q)
      else $error("bus kept although release due");
   a_kind_latch: assert property (@(posedge clk) disable iff (!nrst || proc_reset || prst_q)
      s_idle_edge ##0 d.start |=> cycle_kind == $past(d.kind))
      else $error("cycle kind not latched");
endmodule : arb_proc_side
`default_nettype wire

// ==== logic/arb_status_decode.sv ====
// combinational status decoder: cycle kind and cycle-start detection
`timescale 1ns/1ps
`default_nettype none
`include "arb_cfg.svh"
module arb_status_decode (
   arb_dec_if.dec d
);
   always_comb begin
      case (d.code)
         `ARB_CODE_INTA:  d.kind = arb_pkg::CYC_INTA;
         `ARB_CODE_IORD:  d.kind = arb_pkg::CYC_IORD;
         `ARB_CODE_IOWR:  d.kind = arb_pkg::CYC_IOWR;
         `ARB_CODE_HALT:  d.kind = arb_pkg::CYC_HALT;
         `ARB_CODE_MEMRD: d.kind = arb_pkg::CYC_MEMRD;
         `ARB_CODE_MEMWR: d.kind = arb_pkg::CYC_MEMWR;
         default:         d.kind = arb_pkg::CYC_IDLE;
      endcase
   end
   // either status bit low begins a cycle
   assign d.start = ~d.code[1] | ~d.code[0];
endmodule : arb_status_decode
`default_nettype wire

// ==== shared/arb_cfg.svh ====
// divider reset phase, strap encodings and status codes for the processor-side arbiter
`ifndef ARB_CFG_SVH
`define ARB_CFG_SVH
`define ARB_CODE_INTA    3'h0
`define ARB_CODE_IORD    3'h1
`define ARB_CODE_IOWR    3'h2
`define ARB_CODE_IDLE_IO 3'h3
`define ARB_CODE_HALT    3'h4
`define ARB_CODE_MEMRD   3'h5
`define ARB_CODE_MEMWR   3'h6
`define ARB_CODE_IDLE_M  3'h7
`define ARB_DIV_RESET    1'b0
`define ARB_STRAP_HOLD   1'b1
`define ARB_STRAP_ALWAYS 1'b0
`endif

// ==== shared/arb_dec_if.sv ====
// status decode carrier between the state machine and the decoder
`timescale 1ns/1ps
`default_nettype none
interface arb_dec_if;
   logic [2:0]         code;
   arb_pkg::cyc_kind_e kind;
   logic               start;
   modport dec (input code, output kind, output start);
   modport fsm (output code, input kind, input start);
endinterface : arb_dec_if
`default_nettype wire

// ==== shared/arb_pkg.sv ====
// types shared by the processor-side arbiter
package arb_pkg;
   typedef enum logic [2:0] {
      CYC_INTA, CYC_IORD, CYC_IOWR, CYC_HALT, CYC_MEMRD, CYC_MEMWR, CYC_IDLE
   } cyc_kind_e;
   typedef enum logic [1:0] {ST_IDLE, ST_STATUS, ST_COMMAND} bus_state_e;
endpackage : arb_pkg
